// ==== nicit_host.sv ====
// Model of the host message logic, alternately prompt and slow
`timescale 1ns/1ns
module nicit_host (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic msi_req,
    output logic msi_ack,
    output int fired
);
    int n;
    always_ff @(posedge core_clk) begin
        msi_ack <= rstn && msi_req && !msi_ack && n >= (fired[0] ? 4 : 0);
        n <= rstn && msi_req && !msi_ack ? n + 1 : 0;
        fired <= rstn ? fired + int'(msi_ack) : 0;
    end
endmodule : nicit_host

// ==== nicit_irq_ctrl.sv ====
// Interrupt cause, mask and throttle logic with a plain register port
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// [RL1] A read of the cause register returns the cause bits and clears those that were set then.
// [RL2] Each one written to the cause-set register sets the matching cause bit.
// [RL3] A hardware event in the cycle of a clearing read leaves its cause bit set.
// [RL4] Cause-set writes and coinciding hardware events both take effect.
// [RL5] An interrupt is raised only where cause and mask bits are both one.
// [RL6] Events latch into cause bits whatever the mask holds.
// [RL7] Ones written to mask-set set mask bits, ones to mask-clear clear them, zeros do nothing.
// [RL8] A read of the mask-set register returns the current mask.
// [RL9] Software blocks a cause through the mask-clear register, not by read-modify-write.
// [RL10] With a non-zero interval, pending interrupts are asserted only at spaced slots.
// [RL11] With a zero interval, a pending unmasked interrupt is asserted at once.
// [RL12] Cause bits marked as vector-linked also clear when their vector indication clears.
// [RL13] Interrupts leave as single message requests toward the host message logic.
// [RL14] The interval is a timer in clock units, restarted at each assertion, firing only if pending.
module nicit_irq_ctrl #(
    parameter int NUM_CAUSE = nicit_pkg::NUM_CAUSE,
    parameter int THR_W = nicit_pkg::THR_W,
    parameter logic [NUM_CAUSE-1:0] VEC_LINKED = '0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [nicit_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_CAUSE-1:0] hw_event,
    input wire logic [NUM_CAUSE-1:0] vec_clear,
    output logic msi_req,
    input wire logic msi_ack,
    output logic irq_pending
);
    logic [NUM_CAUSE-1:0] cause_reg;
    logic [NUM_CAUSE-1:0] cause_next;
    logic [NUM_CAUSE-1:0] mask_reg;
    logic [NUM_CAUSE-1:0] mask_next;
    logic [THR_W-1:0] throttle_reg;
    logic [THR_W-1:0] timer_reg;
    logic [THR_W-1:0] timer_next;
    logic msi_req_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    function automatic logic [NUM_CAUSE-1:0] fit(input logic [31:0] d);
        fit = d[NUM_CAUSE-1:0];
    endfunction : fit

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    wire logic wr_cause_set = reg_wr && hit(reg_addr, nicit_pkg::OFF_CAUSE_SET);
    wire logic wr_mask_set = reg_wr && hit(reg_addr, nicit_pkg::OFF_MASK_SET);
    wire logic wr_mask_clr = reg_wr && hit(reg_addr, nicit_pkg::OFF_MASK_CLR);
    wire logic wr_throttle = reg_wr && hit(reg_addr, nicit_pkg::OFF_THROTTLE);
    wire logic rd_cause = reg_rd && hit(reg_addr, nicit_pkg::OFF_CAUSE_READ);
    // Read clears bits seen; linked bits also clear with their vector
    wire logic [NUM_CAUSE-1:0] clr_bits = (rd_cause ? cause_reg : '0)
        | (vec_clear & VEC_LINKED); // see [RL1] see [RL12]
    // Sets win over clears; events latch regardless of mask
    wire logic [NUM_CAUSE-1:0] set_bits = hw_event
        | (wr_cause_set ? fit(reg_wdata) : '0); // see [RL2] see [RL3] see [RL4] see [RL6]
    assign cause_next = (cause_reg & ~clr_bits) | set_bits;
    // Clear port written through its own strobe, so no read-modify-write is needed
    assign mask_next = wr_mask_set ? (mask_reg | fit(reg_wdata)) :
        wr_mask_clr ? (mask_reg & ~fit(reg_wdata)) : mask_reg; // see [RL7] see [RL9]
    wire logic pending = |(cause_reg & mask_reg); // see [RL5]
    wire logic timer_done = (timer_reg == '0);
    // Slot opens at once with zero interval, else at timer expiry
    wire logic slot = (throttle_reg == '0) || timer_done; // see [RL10] see [RL11]
    wire logic fire = pending && slot && !msi_req_reg; // see [RL14]
    assign timer_next = fire ? throttle_reg :
        (timer_done ? timer_reg : timer_reg - 1'b1); // see [RL14]
    wire logic [31:0] cause_w = 32'(cause_reg);
    wire logic [31:0] mask_w = 32'(mask_reg);
    wire logic [31:0] thr_w = 32'(throttle_reg);
    assign rdata_next = !reg_rd ? 32'h0000_0000 :
        hit(reg_addr, nicit_pkg::OFF_CAUSE_READ) ? cause_w :
        hit(reg_addr, nicit_pkg::OFF_MASK_SET) ? mask_w : // see [RL8]
        hit(reg_addr, nicit_pkg::OFF_THROTTLE) ? thr_w :
        hit(reg_addr, nicit_pkg::OFF_STATUS) ? {30'h0000_0000, msi_req_reg, pending} :
        32'h0000_0000;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            cause_reg <= fit(nicit_pkg::CAUSE_RESET);
            mask_reg <= fit(nicit_pkg::MASK_RESET);
            throttle_reg <= THR_W'(nicit_pkg::THROTTLE_RESET);
            timer_reg <= '0;
            msi_req_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            cause_reg <= cause_next;
            mask_reg <= mask_next;
            if (wr_throttle)
                throttle_reg <= reg_wdata[THR_W-1:0];
            timer_reg <= timer_next;
            // Request held until the message logic accepts it
            if (fire)
                msi_req_reg <= 1'b1; // see [RL13]
            else if (msi_ack)
                msi_req_reg <= 1'b0;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign msi_req = msi_req_reg;
    assign irq_pending = pending;
endmodule : nicit_irq_ctrl

// ==== nicit_irq_ctrl_bench.sv ====
// Self-checking bench for the interrupt block
`timescale 1ns/1ns
module nicit_irq_ctrl_bench;
    logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, msi_req, msi_ack, irq_pending;
    logic [3:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, hw_event = '0, reg_rdata, cm = '0, mm = '0, tm = '0;
    logic [31:0] rnd = 32'h2C;
    wire [31:0] vec_clear = rnd;
    int errors = 0, total_checks = 0, fired, f;
    always #50 core_clk = ~core_clk;
    nicit_irq_ctrl dut (.*);
    nicit_host host (.*);
    function automatic logic [31:0] nx();
        return (rnd = {rnd[30:0], ^(rnd & 32'h80200003)}); endfunction : nx
    task automatic chk(string n, logic [31:0] s, e); total_checks++;
        if (s !== e) begin errors++; $display("unexpected %s expected %h seen %h", n, e, s); end
    endtask : chk
    task automatic final_report(); $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish; endtask : final_report
    task automatic op(logic [3:0] a, logic [31:0] d, logic w, r, logic [31:0] h);
        @(posedge core_clk) {reg_addr, reg_wdata, reg_wr, reg_rd, hw_event} <= {a, d, w, r, h};
        @(posedge core_clk) {reg_wr, reg_rd, hw_event} <= '0;
        #1 if (r) chk("rdata", reg_rdata, a == 4'h0 ? cm : a == 4'h2 ? mm : a == 4'h4 ? tm : '0);
        cm = (r && a == 4'h0 ? '0 : cm) | h | (w && a == 4'h1 ? d : '0);
        mm = w && a == 4'h2 ? mm | d : w && a == 4'h3 ? mm & ~d : mm;
        tm = w && a == 4'h4 ? {16'h0000, d[15:0]} : tm; endtask : op
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        op(4'h2, '0, 0, 1, '0); op(4'h9, '0, 0, 1, '0); op(4'h0, '0, 0, 0, nx());
        chk("pend", 32'(irq_pending), '0);
        op(4'h1, nx(), 1, 0, nx()); op(4'h0, '0, 0, 1, nx());
        op(4'h0, '0, 0, 1, '0);
        op(4'h2, nx(), 1, 0, '0); op(4'h3, nx(), 1, 0, '0); op(4'h2, '0, 0, 1, '0);
        op(4'h3, '1, 1, 0, '0); op(4'h1, 32'h1, 1, 0, '0); op(4'h2, 32'h1, 1, 0, '0);
        f = fired;
        repeat (99) @(posedge core_clk);
        chk("fast", 32'(fired - f > 8), 32'h1);
        op(4'h4, 32'h28, 1, 0, '0); op(4'h4, '0, 0, 1, '0);
        f = fired; repeat (400) @(posedge core_clk);
        chk("slots", 32'(fired - f > 7 && fired - f < 12), 32'h1);
        final_report();
    end
    initial begin #200000 errors++; final_report(); end
endmodule : nicit_irq_ctrl_bench

// ==== nicit_irq_ctrl_properties.sv ====
// Checker for the interrupt block
`timescale 1ns/1ns
module nicit_props (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic msi_req,
    input wire logic msi_ack,
    input wire logic irq_pending,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] hw_event
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire rd0 = reg_rd && reg_addr == 4'h0;
    a_rd_idle: assert property (!reg_rd |=> !reg_rdata) else $error("rdata");
    a_rd_clear: assert property (rd0 && !hw_event |=> !irq_pending) else $error("clear");
    a_pend_hold: assert property (irq_pending && !rd0 && !(reg_wr && reg_addr == 4'h3)
        |=> irq_pending) else $error("hold");
    a_mask_off: assert property (reg_wr && reg_addr == 4'h3 && &reg_wdata |=> !irq_pending)
        else $error("mask");
    a_req_hold: assert property (msi_req && !msi_ack |=> msi_req) else $error("req");
    a_ack_drop: assert property (msi_req && msi_ack |=> !msi_req) else $error("ack");
    a_no_fire: assert property (!irq_pending && !msi_req |=> !msi_req) else $error("idle");
    a_fire_src: assert property ($rose(msi_req) |-> $past(irq_pending)) else $error("fire");
    cover property (msi_req && msi_ack);
    cover property (rd0 && hw_event);
    cover property (reg_wr && reg_addr == 4'h3);
endmodule : nicit_props
bind nicit_irq_ctrl nicit_props u_props (.*);

// ==== nicit_pkg.sv ====
// Constants for the interrupt cause, mask and throttle block
package nicit_pkg;
    localparam int NUM_CAUSE = 32;
    localparam int ADDR_W = 4;
    localparam int THR_W = 16;
    localparam logic [3:0] OFF_CAUSE_READ = 4'h0;
    localparam logic [3:0] OFF_CAUSE_SET = 4'h1;
    localparam logic [3:0] OFF_MASK_SET = 4'h2;
    localparam logic [3:0] OFF_MASK_CLR = 4'h3;
    localparam logic [3:0] OFF_THROTTLE = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h5;
    localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [15:0] THROTTLE_RESET = 16'h0000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MSG_PULSE_CYCLES = 1;
endpackage : nicit_pkg
